// >>> src/seqfa_regs.sv
/*
  Sequencing and frequency word A configuration registers with the serial
  configuration slave and the small power-up sequencer they steer.
  Assumes all pins are synchronous to mclk, pclk far slower than mclk,
  and the ADC and filter clocks arrive as one-cycle enables.
*/
`timescale 1ns/10ps
`default_nettype none

// What this block does
// [R1] Select pin falling edge starts sequencing when set
// [R2] Select pin ignored when clear; data pin instead
// [R3] Lock-to-receive wait from 3-bit code table
// [R4] Code seven powers receiver immediately after lock
// [R5] Carrier wait 20 to 32 in twos
// [R6] Carrier wait 36 to 64 by fours, 72
// [R7] Sequencing register resets to 8a hex
// [R8] Offset 04 holds word A top byte
// [R9] Offset 05 holds word A bits 14:7
// [R10] Offset 06 bits 7:1 hold low bits
// [R11] Offset 06 bit 0 enables dithering
// [R12] Data pin starts only with split pins, mode 3
// [R13] Main reset bit low reloads defaults
// [R14] Registers read back last written value
module seqfa_regs
  import seqfa_pkg::*;
(
  input  wire logic        mclk,              // 250 MHz clock
  input  wire logic        reset_n,           // Async reset, active low
  input  wire logic        main_reset_n,      // Soft reset bit, active low
  input  wire logic        psel_n,            // Serial select pin, active low
  input  wire logic        pclk,              // Serial clock pin
  input  wire logic        pdi,               // Serial data in
  output var  logic        pdo,               // Serial data out
  input  wire logic        data_io_pin,       // Data pin level
  input  wire logic        split_data_pins,   // Separate data pins enabled
  input  wire logic [1:0]  power_down_select, // Power-down mode
  input  wire logic        pll_lock,          // Synthesizer in lock
  input  wire logic        adc_clk_en,        // ADC clock period pulse
  input  wire logic        filter_clk_en,     // Filter clock period pulse
  input  wire logic        carrier_sense,     // Carrier sensed
  output var  logic        seq_start,         // Sequence start pulse
  output var  logic        rx_power_up,       // Receiver powered
  output var  logic        rx_power_down,     // Carrier timeout pulse
  output var  logic [22:0] synth_word_a,      // Frequency word A
  output var  logic        dither_enable_a    // Dither for word A
);
  import seqfa_pkg::*;

  typedef enum logic [2:0] {
    S_IDLE = 3'b000, // Waiting for a start edge
    S_LOCK = 3'b001, // Waiting for synthesizer lock
    S_RXW  = 3'b010, // Counting lock-to-receive wait
    S_CSW  = 3'b011, // Receiver on, waiting for carrier
    S_HOLD = 3'b100  // Carrier found, receiver stays on
  } seqfa_state_t;

  logic [7:0]   seq_q, high_q, mid_q, low_q;  // Register file
  logic         psel_prev_q;                  // Edge detect of select
  logic         pclk_prev_q;                  // Edge detect of serial clock
  logic         dio_prev_q;                   // Edge detect of data pin
  logic [4:0]   bit_cnt_q;                    // Bit position in frame
  logic [6:0]   addr_q;                       // Shifted-in address
  logic         wr_q;                         // Frame is a write
  logic [6:0]   dsh_q;                        // Shifted-in data bits
  logic         pdo_q;                        // Serial output bit
  seqfa_state_t state_q;                      // Sequencer state
  logic [8:0]   rxw_cnt_q;                    // Lock-to-receive counter
  logic [6:0]   cs_cnt_q;                     // Carrier-sense counter
  logic         start_q, rx_on_q, pdn_q;      // Sequencer outputs

  // Edge and frame decode
  wire       psel_fall = psel_prev_q & ~psel_n;
  wire       dio_fall  = dio_prev_q & ~data_io_pin;
  wire       pclk_rise = ~psel_n & pclk & ~pclk_prev_q;
  wire       pclk_fall = ~psel_n & ~pclk & pclk_prev_q;
  wire       psel_bit  = seq_q[SEQFA_PSEL_BIT];
  wire [2:0] rxw_code  = seq_q[SEQFA_RXW_MSB:SEQFA_RXW_LSB];
  wire [3:0] csw_code  = seq_q[SEQFA_CSW_MSB:SEQFA_CSW_LSB];

  // Start source selection
  wire start_psel = psel_fall & psel_bit;                       // [R1]
  wire start_dio  = dio_fall & ~psel_bit & split_data_pins
                  & (power_down_select == SEQFA_PD_SEQ);        // [R2] [R12]
  wire start_w    = start_psel | start_dio;

  // Write commit on the last rising serial edge of a write frame
  wire [7:0] wdata  = {dsh_q, pdi};
  wire       commit = pclk_rise & wr_q & (bit_cnt_q == SEQFA_LAST_BIT);
  wire       wr_seq  = commit & (addr_q == SEQFA_ADDR_SEQ);
  wire       wr_high = commit & (addr_q == SEQFA_ADDR_HIGH);
  wire       wr_mid  = commit & (addr_q == SEQFA_ADDR_MID);
  wire       wr_low  = commit & (addr_q == SEQFA_ADDR_LOW);

  // Read mux, unmapped addresses read zero
  wire [7:0] rdata = (addr_q == SEQFA_ADDR_SEQ)  ? seq_q  :
                     (addr_q == SEQFA_ADDR_HIGH) ? high_q :
                     (addr_q == SEQFA_ADDR_MID)  ? mid_q  :
                     (addr_q == SEQFA_ADDR_LOW)  ? low_q  : 8'h00; // [R14]
  // Bit counts 8..15 map onto data bits 7..0, MSB first
  wire [2:0] rd_idx   = ~bit_cnt_q[2:0];
  wire       rd_phase = ~wr_q & bit_cnt_q[3] & ~bit_cnt_q[4];

  // Pin edge history
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      psel_prev_q <= 1'b1;
      pclk_prev_q <= 1'b0;
      dio_prev_q  <= 1'b1;
    end else begin
      psel_prev_q <= psel_n;
      pclk_prev_q <= pclk;
      dio_prev_q  <= data_io_pin;
    end
  end

  // Serial frame: 7 address bits, write flag, 8 data bits
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      bit_cnt_q <= 5'h00;
      addr_q    <= 7'h00;
      wr_q      <= 1'b0;
      dsh_q     <= 7'h00;
    end else if (psel_n) begin
      bit_cnt_q <= 5'h00; // Deselect aborts any partial frame
    end else if (pclk_rise && !bit_cnt_q[4]) begin
      bit_cnt_q <= 5'(bit_cnt_q + 5'h01);
      if (bit_cnt_q < SEQFA_RW_BIT) begin
        addr_q <= {addr_q[5:0], pdi};
      end else if (bit_cnt_q == SEQFA_RW_BIT) begin
        wr_q <= pdi;
      end else begin
        dsh_q <= {dsh_q[5:0], pdi};
      end
    end
  end

  // Read data changes on falling serial edges, held for the host's rise
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      pdo_q <= 1'b0;
    end else if (pclk_fall && rd_phase) begin
      pdo_q <= rdata[rd_idx]; // [R14]
    end
  end

  // Register file; the soft reset bit wins over a write in the same cycle
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      seq_q  <= SEQFA_RST_SEQ;  // [R7]
      high_q <= SEQFA_RST_HIGH;
      mid_q  <= SEQFA_RST_MID;
      low_q  <= SEQFA_RST_LOW;
    end else if (!main_reset_n) begin
      seq_q  <= SEQFA_RST_SEQ;  // [R13]
      high_q <= SEQFA_RST_HIGH;
      mid_q  <= SEQFA_RST_MID;
      low_q  <= SEQFA_RST_LOW;
    end else begin
      if (wr_seq)  seq_q  <= wdata;
      if (wr_high) high_q <= wdata; // [R8]
      if (wr_mid)  mid_q  <= wdata; // [R9]
      if (wr_low)  low_q  <= wdata; // [R10] [R11]
    end
  end

  // Sequencer; a fresh start edge restarts it from any state
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      state_q   <= S_IDLE;
      rxw_cnt_q <= 9'h000;
      cs_cnt_q  <= 7'h00;
      start_q   <= 1'b0;
      rx_on_q   <= 1'b0;
      pdn_q     <= 1'b0;
    end else if (!main_reset_n) begin
      state_q <= S_IDLE;
      start_q <= 1'b0;
      rx_on_q <= 1'b0;
      pdn_q   <= 1'b0;
    end else begin
      start_q <= start_w;
      pdn_q   <= 1'b0;
      if (start_w) begin
        state_q <= S_LOCK;
        rx_on_q <= 1'b0;
      end else begin
        unique case (state_q)
          S_IDLE: ;
          S_LOCK: begin
            if (pll_lock && rxw_code == SEQFA_RXW_NONE) begin
              rx_on_q  <= 1'b1; // [R4]
              cs_cnt_q <= seqfa_cs_wait(csw_code);
              state_q  <= S_CSW;
            end else if (pll_lock) begin
              rxw_cnt_q <= seqfa_rx_wait(rxw_code); // [R3]
              state_q   <= S_RXW;
            end
          end
          S_RXW: begin
            if (adc_clk_en && rxw_cnt_q == 9'h001) begin
              rx_on_q  <= 1'b1; // [R3]
              cs_cnt_q <= seqfa_cs_wait(csw_code); // [R5] [R6]
              state_q  <= S_CSW;
            end else if (adc_clk_en) begin
              rxw_cnt_q <= 9'(rxw_cnt_q - 9'h001);
            end
          end
          S_CSW: begin
            if (carrier_sense) begin
              state_q <= S_HOLD; // Carrier found, keep receiving
            end else if (filter_clk_en && cs_cnt_q == 7'h01) begin
              rx_on_q <= 1'b0; // [R5]
              pdn_q   <= 1'b1;
              state_q <= S_IDLE;
            end else if (filter_clk_en) begin
              cs_cnt_q <= 7'(cs_cnt_q - 7'h01);
            end
          end
          S_HOLD: ;
          default: state_q <= S_IDLE; // Unused codes recover
        endcase
      end
    end
  end

  // Outputs straight from flops
  assign pdo             = pdo_q;
  assign seq_start       = start_q;
  assign rx_power_up     = rx_on_q;
  assign rx_power_down   = pdn_q;
  assign synth_word_a    = {high_q, mid_q, low_q[7:1]}; // [R8] [R9] [R10]
  assign dither_enable_a = low_q[SEQFA_DITH_BIT];      // [R11]

  a_psel_start: assert property (@(posedge mclk) disable iff (!reset_n) // [R1]
    main_reset_n && $fell(psel_n) && seq_q[7] |=> seq_start)
    else $error("select edge did not start sequencing");
  a_psel_ignored: assert property (@(posedge mclk) disable iff (!reset_n) // [R2]
    $fell(psel_n) && !seq_q[7] && !start_dio |=> !seq_start)
    else $error("select edge started sequencing while disabled");
  a_dio_start: assert property (@(posedge mclk) disable iff (!reset_n) // [R12]
    main_reset_n && $fell(data_io_pin) && split_data_pins && !seq_q[7]
    && power_down_select == 2'h3 |=> seq_start)
    else $error("data pin edge did not start sequencing");
  a_rxw_load: assert property (@(posedge mclk) disable iff (!reset_n) // [R3]
    main_reset_n && !start_w && state_q == S_LOCK && pll_lock && rxw_code == 3'h2
    |=> rxw_cnt_q == 9'h040 && !rx_power_up)
    else $error("lock wait loaded with wrong count");
  a_rxw_done: assert property (@(posedge mclk) disable iff (!reset_n) // [R3]
    main_reset_n && !start_w && state_q == S_RXW && adc_clk_en && rxw_cnt_q == 9'h001
    |=> rx_power_up)
    else $error("receiver not powered after lock wait");
  a_no_wait: assert property (@(posedge mclk) disable iff (!reset_n) // [R4]
    main_reset_n && !start_w && state_q == S_LOCK && pll_lock && seq_q[6:4] == 3'h7
    |=> rx_power_up)
    else $error("receiver delayed although wait code is seven");
  a_cs_short: assert property (@(posedge mclk) disable iff (!reset_n) // [R5]
    $rose(rx_power_up) && $past(csw_code) == 4'h3 |-> cs_cnt_q == 7'h1a)
    else $error("carrier wait for short code wrong");
  a_cs_long: assert property (@(posedge mclk) disable iff (!reset_n) // [R6]
    $rose(rx_power_up) && $past(csw_code) == 4'hf |-> cs_cnt_q == 7'h48)
    else $error("carrier wait for code fifteen wrong");
  a_cs_timeout: assert property (@(posedge mclk) disable iff (!reset_n) // [R5]
    main_reset_n && !start_w && state_q == S_CSW && !carrier_sense && filter_clk_en
    && cs_cnt_q == 7'h01 |=> rx_power_down && !rx_power_up ##1 !rx_power_down)
    else $error("no power down after carrier timeout");
  a_soft_defaults: assert property (@(posedge mclk) disable iff (!reset_n) // [R13]
    !main_reset_n |=> seq_q == 8'h8a && synth_word_a == {8'h83, 8'hb1, 7'h7c}
    && dither_enable_a)
    else $error("soft reset did not load defaults");
  a_hi_write: assert property (@(posedge mclk) disable iff (!reset_n) // [R8]
    main_reset_n && wr_high |=> synth_word_a[22:15] == $past(wdata))
    else $error("top byte of word A not written");
  // Sequence ends two edges after the commit, so the written byte is two back
  a_readback: assert property (@(posedge mclk) disable iff (!reset_n) // [R14]
    main_reset_n && wr_low ##1 (main_reset_n && !commit)[*2]
    |-> addr_q != 7'h06 || rdata == $past(wdata, 2) || !$stable(addr_q))
    else $error("register readback differs from written value");

endmodule // seqfa_regs

`default_nettype wire

// >>> src/seqfa_pkg.sv
/*
  Constants for the power-up sequencing and frequency word A register bank:
  serial addresses, field positions, reset values and wait-time lookups.
  Assumes nothing of its surroundings; every design file imports it whole.
*/
`default_nettype none

package seqfa_pkg;

  // Serial register addresses (7-bit address field)
  localparam logic [6:0] SEQFA_ADDR_SEQ  = 7'h03; // Sequencing config
  localparam logic [6:0] SEQFA_ADDR_HIGH = 7'h04; // Word A bits 22:15
  localparam logic [6:0] SEQFA_ADDR_MID  = 7'h05; // Word A bits 14:7
  localparam logic [6:0] SEQFA_ADDR_LOW  = 7'h06; // Word A bits 6:0 and dither

  // Values after reset
  localparam logic [7:0] SEQFA_RST_SEQ  = 8'h8a; // Pin start 1, wait 0, cs 10
  localparam logic [7:0] SEQFA_RST_HIGH = 8'h83; // 131
  localparam logic [7:0] SEQFA_RST_MID  = 8'hb1; // 177
  localparam logic [7:0] SEQFA_RST_LOW  = 8'hf9; // 124 shifted, dither on

  // Field positions
  localparam int SEQFA_PSEL_BIT = 7; // Select pin starts sequencing
  localparam int SEQFA_RXW_MSB  = 6; // Lock-to-receive wait code
  localparam int SEQFA_RXW_LSB  = 4;
  localparam int SEQFA_CSW_MSB  = 3; // Carrier-sense wait code
  localparam int SEQFA_CSW_LSB  = 0;
  localparam int SEQFA_DITH_BIT = 0; // Dither enable in low byte

  // Codes and frame geometry
  localparam logic [2:0] SEQFA_RXW_NONE = 3'h7; // No wait after lock
  localparam logic [1:0] SEQFA_PD_SEQ   = 2'h3; // Power-down mode with sequencing
  localparam logic [4:0] SEQFA_RW_BIT   = 5'h07; // Bit index of write flag
  localparam logic [4:0] SEQFA_LAST_BIT = 5'h0f; // Last data bit of a frame

  // Lock-to-receive wait, in ADC clock periods
  function automatic logic [8:0] seqfa_rx_wait(input logic [2:0] code);
    logic [8:0] n;
    n = 9'h020;
    case (code)
      3'h0: n = 9'h020; // 32
      3'h1: n = 9'h02c; // 44
      3'h2: n = 9'h040; // 64
      3'h3: n = 9'h058; // 88
      3'h4: n = 9'h080; // 128
      3'h5: n = 9'h0b0; // 176
      default: n = 9'h100; // 256, code 7 never loads
    endcase
    return n;
  endfunction

  // Carrier-sense wait, in filter clock periods
  function automatic logic [6:0] seqfa_cs_wait(input logic [3:0] code);
    logic [6:0] n;
    n = 7'h14;
    if (code == 4'hf) begin
      n = 7'h48; // 72
    end else if (code >= 4'h7) begin
      n = 7'(7'h24 + {code - 4'h7, 2'h0}); // 36..64 in fours
    end else begin
      n = 7'(7'h14 + {2'h0, code, 1'h0}); // 20..32 in twos
    end
    return n;
  endfunction

endpackage

`default_nettype wire

// >>> verif/seqfa_host.sv
/*
  Host microcontroller model for the serial configuration pins.
  Assumes the device samples the pins on mclk; the bench calls its tasks
  just after a rising mclk edge.
*/
`timescale 1ns/10ps
`default_nettype none

module seqfa_host (
  input  wire logic mclk,   // Device clock
  output var  logic psel_n, // Select pin, active low
  output var  logic pclk,   // Serial clock
  output var  logic pdi,    // Data to device
  input  wire logic pdo     // Data from device
);
  // Idle pins at time zero
  initial begin
    psel_n = 1'b1;
    pclk = 1'b0;
    pdi = 1'b0;
  end

  // Let n edges pass, then step off the edge
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  // One whole frame; three-cycle phases clear the two-cycle minimum
  task automatic xfer(input logic [6:0] a, input logic wr,
                      input logic [7:0] d, output logic [7:0] q);
    logic [15:0] f;
    f = {a, wr, d};
    q = 8'h00;
    psel_n = 1'b0;
    for (int i = 0; i < 16; i++) begin
      pdi = f[15-i];
      tick(3);
      if (i >= 8) q = {q[6:0], pdo}; // Read bits land after each fall
      pclk = 1'b1;
      tick(3);
      pclk = 1'b0;
    end
    tick(3);
    psel_n = 1'b1;
    pdi = ~pdi; // Released line must not show the stale bit
    tick(3);
  endtask

  // Bare select pulse, no clock
  task automatic sel_pulse;
    psel_n = 1'b0;
    tick(3);
    psel_n = 1'b1;
    tick(3);
  endtask
endmodule // seqfa_host

`default_nettype wire

// >>> verif/seqfa_regs_tb.sv
/*
  Self-checking bench for the sequencing and word A register bank.
  Assumes seqfa_host drives the serial pins; the bench drives the rest.
*/
`timescale 1ns/10ps
`default_nettype none
`define CHK(g,e,m) begin checks++; if ((g)!==(e)) begin n_mismatch++; \
  $display("unexpected %0t: %s", $time, m); end end

module seqfa_regs_tb;
  logic        mclk = 0, reset_n = 0, main_reset_n = 1;
  logic        psel_n, pclk, pdi, pdo, seq_start, rx_power_up, rx_power_down;
  logic        data_io_pin = 1, split_data_pins = 0, pll_lock = 0;
  logic [1:0]  power_down_select = 2'h0;
  logic        adc_clk_en = 0, filter_clk_en = 0, carrier_sense = 0;
  logic [22:0] synth_word_a;
  logic        dither_enable_a;
  int          n_mismatch = 0, checks = 0, n_start = 0;
  int          rxw [8] = '{32, 44, 64, 88, 128, 176, 256, 0}; // Code 7: none

  seqfa_regs u_seqfa_regs (.mclk(mclk), .reset_n(reset_n),
    .main_reset_n(main_reset_n), .psel_n(psel_n), .pclk(pclk), .pdi(pdi),
    .pdo(pdo), .data_io_pin(data_io_pin), .split_data_pins(split_data_pins),
    .power_down_select(power_down_select), .pll_lock(pll_lock),
    .adc_clk_en(adc_clk_en), .filter_clk_en(filter_clk_en),
    .carrier_sense(carrier_sense), .seq_start(seq_start),
    .rx_power_up(rx_power_up), .rx_power_down(rx_power_down),
    .synth_word_a(synth_word_a), .dither_enable_a(dither_enable_a));
  seqfa_host u_seqfa_host (.mclk(mclk), .psel_n(psel_n), .pclk(pclk),
    .pdi(pdi), .pdo(pdo));

  always #2 mclk = ~mclk; // 250 MHz
  // Start pulses seen, cleared by each scenario; the falling edge keeps the
  // count clear of the edge that launches the pulse
  always @(negedge mclk) if (seq_start === 1'b1) n_start++;

  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    logic [7:0] q;
    u_seqfa_host.xfer(a, 1'b1, d, q);
  endtask
  task automatic rchk(input logic [6:0] a, input logic [7:0] e, input string m);
    logic [7:0] q;
    u_seqfa_host.xfer(a, 1'b0, 8'h00, q);
    `CHK(q, e, m)
  endtask
  // One enable pulse on the chosen strobe; samples the answer after its edge
  task automatic pulse(input bit flt, output logic up, output logic dn);
    if (flt) filter_clk_en = 1; else adc_clk_en = 1;
    tick(1);
    filter_clk_en = 0;
    adc_clk_en = 0;
    up = rx_power_up;
    dn = rx_power_down;
    tick(1);
  endtask

  task automatic t_defaults;
    `CHK(synth_word_a, {8'h83, 8'hb1, 7'h7c}, "word a default")
    `CHK(dither_enable_a, 1'b1, "dither default")
    rchk(7'h03, 8'h8a, "seq default");
    rchk(7'h06, 8'hf9, "low default");
    $display("done t_defaults");
  endtask

  task automatic t_readback;
    wr(7'h04, 8'h55);
    wr(7'h05, 8'haa);
    wr(7'h06, 8'h3c);
    wr(7'h07, 8'hff); // Unmapped, dropped
    `CHK(synth_word_a, {8'h55, 8'haa, 7'h1e}, "word a write")
    `CHK(dither_enable_a, 1'b0, "dither off")
    rchk(7'h05, 8'haa, "mid readback");
    rchk(7'h06, 8'h3c, "low readback");
    rchk(7'h07, 8'h00, "unmapped read");
    main_reset_n = 0; // Soft reset for one cycle
    tick(1);
    main_reset_n = 1;
    tick(1);
    `CHK(synth_word_a, {8'h83, 8'hb1, 7'h7c}, "soft reset word")
    rchk(7'h04, 8'h83, "soft reset high");
    $display("done t_readback");
  endtask

  // Table entries: split pins, mode, start expected
  task automatic t_starts;
    logic [3:0] tb [3] = '{4'hf, 4'hc, 4'h6};
    wr(7'h03, 8'h8a);
    n_start = 0;
    u_seqfa_host.sel_pulse();
    `CHK(n_start, 1, "select start")
    wr(7'h03, 8'h0a);
    n_start = 0;
    u_seqfa_host.sel_pulse();
    `CHK(n_start, 0, "select ignored")
    for (int k = 0; k < 3; k++) begin
      {split_data_pins, power_down_select} = tb[k][3:1];
      tick(2);
      n_start = 0;
      data_io_pin = 0;
      tick(3);
      data_io_pin = 1;
      tick(3);
      `CHK(n_start, int'(tb[k][0]), "data pin start")
    end
    $display("done t_starts");
  endtask

  // Every carrier wait code once, each lock wait code twice: lock wait, then carrier timeout
  task automatic t_waits;
    int n;
    int e;
    logic up, dn;
    for (int i = 0; i < 16; i++) begin
      wr(7'h03, {1'b1, 3'(i % 8), 4'(i)});
      u_seqfa_host.sel_pulse();
      pll_lock = 1;
      tick(1);
      n = 0;
      up = rx_power_up;
      while (up !== 1'b1 && n < 300) begin
        pulse(0, up, dn);
        n++;
      end
      `CHK(n, rxw[i % 8], "lock wait")
      e = i < 7 ? 20 + 2 * i : i < 15 ? 36 + 4 * (i - 7) : 72;
      n = 0;
      dn = 0;
      while (dn !== 1'b1 && n < 100) begin
        pulse(1, up, dn);
        n++;
      end
      `CHK(n, e, "carrier wait")
      `CHK(up, 1'b0, "receiver off")
      pll_lock = 0;
    end
    $display("done t_waits");
  endtask

  task automatic t_hold;
    logic up, dn;
    wr(7'h03, 8'hf0);
    u_seqfa_host.sel_pulse();
    carrier_sense = 1;
    pll_lock = 1;
    tick(2);
    repeat (30) pulse(1, up, dn);
    `CHK(up, 1'b1, "carrier holds")
    carrier_sense = 0;
    pll_lock = 0;
    u_seqfa_host.sel_pulse();
    `CHK(rx_power_up, 1'b0, "restart drops")
    $display("done t_hold");
  endtask

  task automatic close_out;
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  initial begin
    tick(10);
    reset_n = 1;
    tick(2);
    t_defaults();
    t_readback();
    t_starts();
    t_waits();
    t_hold();
    close_out();
  end
  // Runs need about 7.7k cycles
  initial begin
    #300000;
    n_mismatch++;
    close_out();
  end
endmodule // seqfa_regs_tb

`default_nettype wire
